// ==== pasr_checker.sv ====
`timescale 1ns/10ps
module pasr_checker
  import pasr_pkg::*;
(
  // link domain
  input wire logic link_clk,
  input wire logic rst,
  input wire logic strap_arb_sel,
  input wire logic strap_host_sel,
  // device drives
  input wire logic [NUM_REQ-1:0] req_dev_o,
  input wire logic [NUM_REQ-1:0] req_dev_oe_n,
  input wire logic [NUM_GNT-1:0] gnt_dev_oe_n,
  input wire logic serr_dev_o,
  input wire logic serr_dev_oe_n,
  input wire logic devsel_dev_o,
  input wire logic devsel_dev_oe_n
);
  logic arb_r;
  logic host_r;
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (rst);
  // ****
  // straps as seen in reset
  // ****
  always_ff @(posedge link_clk)
  begin
    if (rst)
    begin
      arb_r <= strap_arb_sel;
      host_r <= strap_host_sel;
    end
  end
  sequence s_int;
    arb_r == STRAP_ARB_INTERNAL;
  endsequence
  sequence s_ext;
    arb_r != STRAP_ARB_INTERNAL;
  endsequence
  AST_REQ_UPPER_IN: assert property (req_dev_oe_n[3:2] == 2'b11)
    else $error("upper request pins driven");
  AST_INT_REQ_IN: assert property (s_int |-> req_dev_oe_n[1:0] == 2'b11)
    else $error("lower request pins driven");
  AST_EXT_OWN_REQ: assert property (s_ext |-> req_dev_oe_n[0] == OE_DRIVE)
    else $error("own request not driven");
  AST_EXT_IRQ_OD: assert property (s_ext ##0 !req_dev_oe_n[1] |-> !req_dev_o[1])
    else $error("interrupt pin driven high");
  AST_INT_GNT_OUT: assert property (s_int |-> gnt_dev_oe_n == 4'h0)
    else $error("grant pins not driven");
  AST_EXT_GNT_IN: assert property (s_ext |-> gnt_dev_oe_n == 4'hf)
    else $error("grant pins driven");
  AST_HOST_SERR_IN: assert property (host_r |-> serr_dev_oe_n == OE_RELEASE)
    else $error("host drives system error");
  AST_SERR_OD: assert property (!serr_dev_oe_n |-> serr_dev_o == PIN_ASSERT)
    else $error("system error driven high");
  AST_DEVSEL_LOW: assert property (!devsel_dev_oe_n |-> !devsel_dev_o)
    else $error("device select driven high");
endmodule // pasr_checker

// ==== pasr_dev.sv ====
`timescale 1ns/10ps
// Overview of operation
// - arbiter strap picks internal or external arbiter
// - internal: request pins 3..2 are inputs
// - external: request pins 3..2 ignored inputs
// - internal: request pins 1..0 are inputs
// - external: request 1 open-drain interrupt, released
// - external: request 0 driven own request, high
// - internal: four grants driven, start high
// - external: grant 0 input, grants 3..1 unused
// - host strap: system error input or open-drain
// - system error reports address parity, special data parity or fatal errors
// - parity error reports non-special data errors
// - config access only while select is asserted
// - target asserts device select on access
module pasr_dev
  import pasr_pkg::*;
(
  // link
  pasr_link_if.dev link,
  // reset and straps, link clock domain
  input wire logic rst,
  input wire logic strap_arb_sel,
  input wire logic strap_host_sel,
  // internal arbiter side
  input wire logic [NUM_GNT-1:0] grant_vec,
  output logic [NUM_REQ-1:0] req_seen,
  // own master side
  input wire logic own_req,
  output logic own_gnt,
  input wire logic external_interrupt_out,
  // error and target side
  input wire logic fatal_err,
  input wire logic addr_par_err,
  input wire logic special_data_par_err,
  input wire logic data_par_err,
  output logic serr_seen,
  output logic perr_seen,
  input wire logic cfg_hit,
  input wire logic mem_hit,
  output logic cfg_access,
  output logic internal_arb,
  output logic host_mode
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    pasr_state_t st;
    logic arb_int;
    logic host;
    // stages of the strap, select and pin synchronisers
    logic strap_arb_s1;
    logic strap_host_s1;
    logic idsel_s1;
    logic idsel_s2;
    logic [NUM_REQ-1:0] req_s1;
    logic [NUM_REQ-1:0] req_s2;
    logic [NUM_GNT-1:0] gnt_s1;
    logic [NUM_GNT-1:0] gnt_s2;
    logic serr_s1;
    logic serr_s2;
    logic perr_s1;
    logic perr_s2;
    logic [NUM_REQ-1:0] req_seen;
    logic own_gnt;
    logic serr_seen;
    logic perr_seen;
    logic cfg;
    logic req_o0;
    logic irq_o;
    logic [NUM_GNT-1:0] gnt_o;
    logic serr_o;
    logic perr_o;
    logic devsel_o;
  } pasr_dev_state_t;

  pasr_dev_state_t s_r;
  pasr_dev_state_t s_nxt;

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    s_nxt = s_r;
    // board pins and straps cross into the link clock through two flops
    s_nxt.strap_arb_s1 = strap_arb_sel;
    s_nxt.strap_host_s1 = strap_host_sel;
    s_nxt.idsel_s1 = link.idsel;
    s_nxt.idsel_s2 = s_r.idsel_s1;
    s_nxt.req_s1 = link.req_wire;
    s_nxt.req_s2 = s_r.req_s1;
    s_nxt.gnt_s1 = link.gnt_wire;
    s_nxt.gnt_s2 = s_r.gnt_s1;
    s_nxt.serr_s1 = link.serr_wire;
    s_nxt.serr_s2 = s_r.serr_s1;
    s_nxt.perr_s1 = link.perr_wire;
    s_nxt.perr_s2 = s_r.perr_s1;
    if (rst)
    begin
      // boot levels: pins released except those the strap makes outputs
      s_nxt.st = PASR_ST_RESET;
      s_nxt.arb_int = (s_r.strap_arb_s1 == STRAP_ARB_INTERNAL);
      s_nxt.host = (s_r.strap_host_s1 == STRAP_HOST);
      s_nxt.req_s1 = {NUM_REQ{PIN_DEASSERT}};
      s_nxt.req_s2 = {NUM_REQ{PIN_DEASSERT}};
      s_nxt.gnt_s1 = {NUM_GNT{PIN_DEASSERT}};
      s_nxt.gnt_s2 = {NUM_GNT{PIN_DEASSERT}};
      s_nxt.serr_s1 = PIN_DEASSERT;
      s_nxt.serr_s2 = PIN_DEASSERT;
      s_nxt.perr_s1 = PIN_DEASSERT;
      s_nxt.perr_s2 = PIN_DEASSERT;
      s_nxt.req_seen = '0;
      s_nxt.own_gnt = 1'b0;
      s_nxt.serr_seen = 1'b0;
      s_nxt.perr_seen = 1'b0;
      s_nxt.cfg = 1'b0;
      s_nxt.req_o0 = PIN_DEASSERT;
      s_nxt.irq_o = PIN_DEASSERT;
      s_nxt.gnt_o = {NUM_GNT{PIN_DEASSERT}};
      s_nxt.serr_o = PIN_DEASSERT;
      s_nxt.perr_o = PIN_DEASSERT;
      s_nxt.devsel_o = PIN_DEASSERT;
    end
    else
    begin
      case (s_r.st)
        PASR_ST_RESET:
        begin
          // last look at the straps, then they stay put until the next reset
          s_nxt.arb_int = (s_r.strap_arb_s1 == STRAP_ARB_INTERNAL);
          s_nxt.host = (s_r.strap_host_s1 == STRAP_HOST);
          s_nxt.st = PASR_ST_RUN;
        end
        PASR_ST_RUN:
        begin
          // straps are frozen here; only pins and user inputs move
          if (s_r.arb_int)
          begin
            s_nxt.req_seen = ~s_r.req_s2;
            s_nxt.gnt_o = ~grant_vec;
            s_nxt.own_gnt = 1'b0;
          end
          else
          begin
            s_nxt.req_seen = '0;
            s_nxt.gnt_o = {NUM_GNT{PIN_DEASSERT}};
            s_nxt.own_gnt = ~s_r.gnt_s2[GNT_OWN_BIT];
          end
          s_nxt.req_o0 = ~own_req;
          s_nxt.irq_o = ~external_interrupt_out;
          s_nxt.serr_o = ~(fatal_err | addr_par_err | special_data_par_err);
          s_nxt.perr_o = ~data_par_err;
          s_nxt.serr_seen = ~s_r.serr_s2;
          s_nxt.perr_seen = ~s_r.perr_s2;
          s_nxt.cfg = cfg_hit & s_r.idsel_s2;
          s_nxt.devsel_o = ~(s_nxt.cfg | mem_hit);
        end
        default:
        begin
          s_nxt.st = PASR_ST_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge link.link_clk)
  begin
    s_r <= s_nxt;
  end

  // ****************************************
  // pin drive
  // ****************************************
  // open-drain pins only ever pull low; the board pull-up gives the high level
  always_comb
  begin
    link.req_dev_o = {NUM_REQ{PIN_DEASSERT}};
    link.req_dev_oe_n = {NUM_REQ{OE_RELEASE}};
    if (!s_r.arb_int)
    begin
      link.req_dev_o[REQ_OWN_BIT] = s_r.req_o0;
      link.req_dev_oe_n[REQ_OWN_BIT] = OE_DRIVE;
      link.req_dev_o[REQ_IRQ_BIT] = PIN_ASSERT;
      link.req_dev_oe_n[REQ_IRQ_BIT] = s_r.irq_o ? OE_RELEASE : OE_DRIVE;
    end
    link.gnt_dev_o = s_r.gnt_o;
    link.gnt_dev_oe_n = s_r.arb_int ? {NUM_GNT{OE_DRIVE}} : {NUM_GNT{OE_RELEASE}};
    link.serr_dev_o = PIN_ASSERT;
    link.serr_dev_oe_n = (!s_r.host && !s_r.serr_o) ? OE_DRIVE : OE_RELEASE;
    link.perr_dev_o = s_r.perr_o;
    link.perr_dev_oe_n = s_r.perr_o ? OE_RELEASE : OE_DRIVE;
    link.devsel_dev_o = s_r.devsel_o;
    link.devsel_dev_oe_n = s_r.devsel_o ? OE_RELEASE : OE_DRIVE;
  end

  // ****************************************
  // outputs
  // ****************************************

  assign req_seen = s_r.req_seen;
  assign own_gnt = s_r.own_gnt;
  assign serr_seen = s_r.serr_seen;
  assign perr_seen = s_r.perr_seen;
  assign cfg_access = s_r.cfg;
  assign internal_arb = s_r.arb_int;
  assign host_mode = s_r.host;

endmodule // pasr_dev

// ==== pasr_far.sv ====
`timescale 1ns/10ps
module pasr_far
  import pasr_pkg::*;
(
  // link
  pasr_link_if.far link,
  // system clock side
  input wire logic clock,
  input wire logic rst,
  // mode of the board
  input wire logic ext_arbiter,
  // user requests, clock domain
  input wire logic [NUM_REQ-1:0] master_req,
  input wire logic [NUM_GNT-1:0] ext_grant,
  input wire logic cfg_select,
  input wire logic assert_serr,
  input wire logic assert_perr,
  input wire logic assert_devsel,
  // observed, synchronised into clock domain
  output logic [NUM_GNT-1:0] grant_seen,
  output logic [NUM_REQ-1:0] req_pin_seen,
  output logic serr_seen,
  output logic devsel_seen
);

  // ****************************************
  // state: clock domain samplers
  // ****************************************
  typedef struct packed {
    logic [NUM_GNT-1:0] g1;
    logic [NUM_GNT-1:0] g2;
    logic [NUM_REQ-1:0] r1;
    logic [NUM_REQ-1:0] r2;
    logic s1;
    logic s2;
    logic d1;
    logic d2;
  } pasr_far_state_t;

  pasr_far_state_t s_r;
  pasr_far_state_t s_nxt;

  always_comb
  begin
    s_nxt.g1 = ~link.gnt_wire;
    s_nxt.g2 = s_r.g1;
    s_nxt.r1 = ~link.req_wire;
    s_nxt.r2 = s_r.r1;
    s_nxt.s1 = ~link.serr_wire;
    s_nxt.s2 = s_r.s1;
    s_nxt.d1 = ~link.devsel_wire;
    s_nxt.d2 = s_r.d1;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // pin drive, board pull-ups resolve released pins
  // ****************************************
  always_comb
  begin
    link.req_far_o = ~master_req;
    link.req_far_oe_n = {NUM_REQ{OE_RELEASE}};
    link.gnt_far_o = ~ext_grant;
    link.gnt_far_oe_n = {NUM_GNT{OE_RELEASE}};
    if (ext_arbiter)
    begin
      link.gnt_far_oe_n[GNT_OWN_BIT] = OE_DRIVE;
    end
    else
    begin
      link.req_far_oe_n = ~master_req;
    end
    link.serr_far_o = PIN_ASSERT;
    link.serr_far_oe_n = assert_serr ? OE_DRIVE : OE_RELEASE;
    link.perr_far_o = PIN_ASSERT;
    link.perr_far_oe_n = assert_perr ? OE_DRIVE : OE_RELEASE;
    link.devsel_far_o = PIN_ASSERT;
    link.devsel_far_oe_n = assert_devsel ? OE_DRIVE : OE_RELEASE;
    link.idsel = cfg_select;
  end

  assign grant_seen = s_r.g2;
  assign req_pin_seen = s_r.r2;
  assign serr_seen = s_r.s2;
  assign devsel_seen = s_r.d2;

endmodule // pasr_far

// ==== pasr_link_if.sv ====
`timescale 1ns/10ps
interface pasr_link_if;
  import pasr_pkg::*;
  logic link_clk;
  // request pins, active low: device and far outputs and enables, and the wire
  logic [NUM_REQ-1:0] req_dev_o;
  logic [NUM_REQ-1:0] req_dev_oe_n;
  logic [NUM_REQ-1:0] req_far_o;
  logic [NUM_REQ-1:0] req_far_oe_n;
  logic [NUM_REQ-1:0] req_wire;
  // grant pins, active low
  logic [NUM_GNT-1:0] gnt_dev_o;
  logic [NUM_GNT-1:0] gnt_dev_oe_n;
  logic [NUM_GNT-1:0] gnt_far_o;
  logic [NUM_GNT-1:0] gnt_far_oe_n;
  logic [NUM_GNT-1:0] gnt_wire;
  // system error and parity error, active low
  logic serr_dev_o;
  logic serr_dev_oe_n;
  logic serr_far_o;
  logic serr_far_oe_n;
  logic serr_wire;
  logic perr_dev_o;
  logic perr_dev_oe_n;
  logic perr_far_o;
  logic perr_far_oe_n;
  logic perr_wire;
  // configuration select and device select
  logic idsel;
  logic devsel_dev_o;
  logic devsel_dev_oe_n;
  logic devsel_far_o;
  logic devsel_far_oe_n;
  logic devsel_wire;

  // wired resolution with board pull-ups
  always_comb
  begin
    for (int i = 0; i < NUM_REQ; i++)
    begin
      req_wire[i] = ((req_dev_oe_n[i] == OE_DRIVE) ? req_dev_o[i] : 1'b1)
        & ((req_far_oe_n[i] == OE_DRIVE) ? req_far_o[i] : 1'b1);
    end
    for (int j = 0; j < NUM_GNT; j++)
    begin
      gnt_wire[j] = ((gnt_dev_oe_n[j] == OE_DRIVE) ? gnt_dev_o[j] : 1'b1)
        & ((gnt_far_oe_n[j] == OE_DRIVE) ? gnt_far_o[j] : 1'b1);
    end
    serr_wire = ((serr_dev_oe_n == OE_DRIVE) ? serr_dev_o : 1'b1)
      & ((serr_far_oe_n == OE_DRIVE) ? serr_far_o : 1'b1);
    perr_wire = ((perr_dev_oe_n == OE_DRIVE) ? perr_dev_o : 1'b1)
      & ((perr_far_oe_n == OE_DRIVE) ? perr_far_o : 1'b1);
    devsel_wire = ((devsel_dev_oe_n == OE_DRIVE) ? devsel_dev_o : 1'b1)
      & ((devsel_far_oe_n == OE_DRIVE) ? devsel_far_o : 1'b1);
  end

  modport dev (
    input link_clk, req_wire, gnt_wire, serr_wire, perr_wire, idsel, devsel_wire,
    output req_dev_o, req_dev_oe_n, gnt_dev_o, gnt_dev_oe_n, serr_dev_o, serr_dev_oe_n,
    output perr_dev_o, perr_dev_oe_n, devsel_dev_o, devsel_dev_oe_n
  );
  modport far (
    input link_clk, req_wire, gnt_wire, serr_wire, perr_wire, devsel_wire,
    output req_far_o, req_far_oe_n, gnt_far_o, gnt_far_oe_n, serr_far_o, serr_far_oe_n,
    output perr_far_o, perr_far_oe_n, devsel_far_o, devsel_far_oe_n, idsel
  );
endinterface

// ==== pasr_pkg.sv ====
package pasr_pkg;
  // ****************************************
  // pin counts and levels
  // ****************************************
  localparam int NUM_REQ = 4;
  localparam int NUM_GNT = 4;
  localparam logic STRAP_ARB_INTERNAL = 1'b1;
  localparam logic STRAP_HOST = 1'b1;
  localparam logic PIN_DEASSERT = 1'b1;
  localparam logic PIN_ASSERT = 1'b0;
  localparam logic OE_DRIVE = 1'b0;
  localparam logic OE_RELEASE = 1'b1;
  localparam int REQ_OWN_BIT = 0;
  localparam int REQ_IRQ_BIT = 1;
  localparam int GNT_OWN_BIT = 0;

  typedef enum logic [1:0] {
    PASR_ST_RESET,
    PASR_ST_RUN
  } pasr_state_t;
endpackage

// ==== tb.sv ====
`timescale 1ns/10ps
module tb;
  import pasr_pkg::*;
  logic clock = 0;
  logic rst = 1;
  logic strap_arb_sel, strap_host_sel, ext_arbiter, own_req, external_interrupt_out;
  logic fatal_err, addr_par_err, special_data_par_err, data_par_err, cfg_hit, mem_hit;
  logic cfg_select, assert_serr, assert_perr, assert_devsel, d_own_gnt, d_serr, d_perr;
  logic d_cfg, d_arb, d_host, f_serr, f_devsel;
  logic [3:0] grant_vec, master_req, ext_grant, d_req, f_gnt, f_req;
  int mismatches = 0;
  int n_checks = 0;
  pasr_link_if link();
  // ****
  // clocks and ends
  // ****
  always #4 clock = ~clock;
  initial
  begin
    link.link_clk = 0;
    #1.3;
    forever #6 link.link_clk = ~link.link_clk;
  end
  pasr_dev i_pasr_dev (.link(link), .rst(rst), .strap_arb_sel(strap_arb_sel),
    .strap_host_sel(strap_host_sel), .grant_vec(grant_vec), .req_seen(d_req),
    .own_req(own_req), .own_gnt(d_own_gnt), .external_interrupt_out(external_interrupt_out),
    .fatal_err(fatal_err), .addr_par_err(addr_par_err), .data_par_err(data_par_err),
    .special_data_par_err(special_data_par_err), .serr_seen(d_serr), .perr_seen(d_perr),
    .cfg_hit(cfg_hit), .mem_hit(mem_hit), .cfg_access(d_cfg), .internal_arb(d_arb),
    .host_mode(d_host));
  pasr_far i_pasr_far (.link(link), .clock(clock), .rst(rst), .ext_arbiter(ext_arbiter),
    .master_req(master_req), .ext_grant(ext_grant), .cfg_select(cfg_select),
    .assert_serr(assert_serr), .assert_perr(assert_perr), .assert_devsel(assert_devsel),
    .grant_seen(f_gnt), .req_pin_seen(f_req), .serr_seen(f_serr), .devsel_seen(f_devsel));
  pasr_checker i_pasr_checker (.link_clk(link.link_clk), .rst(rst),
    .strap_arb_sel(strap_arb_sel), .strap_host_sel(strap_host_sel),
    .req_dev_o(link.req_dev_o), .req_dev_oe_n(link.req_dev_oe_n),
    .gnt_dev_oe_n(link.gnt_dev_oe_n), .serr_dev_o(link.serr_dev_o),
    .serr_dev_oe_n(link.serr_dev_oe_n), .devsel_dev_o(link.devsel_dev_o),
    .devsel_dev_oe_n(link.devsel_dev_oe_n));
  // ****
  // helpers
  // ****
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // wait covers three link flops, or one link flop plus two sync edges
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic start(input logic a, input logic h);
    {grant_vec, master_req, ext_grant, own_req, external_interrupt_out, fatal_err,
      addr_par_err, special_data_par_err, data_par_err, cfg_hit, mem_hit, cfg_select,
      assert_serr, assert_perr, assert_devsel} = '0;
    strap_arb_sel = a;
    strap_host_sel = h;
    ext_arbiter = ~a;
    rst = 1;
    wt(3);
    rst = 0;
    wt(8);
  endtask
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_int;
    start(1'b1, 1'b1);
    check(link.gnt_wire, 4'hf);
    check({d_arb, d_host}, 2'b11);
    grant_vec = 4'h5;
    master_req = 4'ha;
    ext_grant = 4'h1;
    cfg_hit = 1;
    fatal_err = 1;
    strap_arb_sel = 0;
    wt(8);
    check(f_gnt, 4'h5);
    check(d_req, 4'ha);
    check(d_own_gnt, 1'b0);
    check({d_cfg, f_devsel}, 2'b00);
    check({f_serr, d_arb}, 2'b01);
    assert_serr = 1;
    cfg_select = 1;
    wt(8);
    check({d_serr, d_cfg, f_devsel}, 3'b111);
  endtask
  task automatic t_ext;
    start(1'b0, 1'b0);
    check(link.req_wire[1:0], 2'b11);
    check({d_arb, d_host}, 2'b00);
    own_req = 1;
    external_interrupt_out = 1;
    master_req = 4'hc;
    ext_grant = 4'h1;
    grant_vec = 4'hf;
    data_par_err = 1;
    wt(8);
    check(f_req[1:0], 2'b11);
    check(d_req, 4'h0);
    check({d_own_gnt, f_gnt}, 5'h11);
    check(link.perr_wire, 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      {fatal_err, addr_par_err, special_data_par_err} = 3'b001 << i;
      wt(8);
      check(f_serr, 1'b1);
      {fatal_err, addr_par_err, special_data_par_err} = 3'b000;
      wt(8);
      check(f_serr, 1'b0);
    end
    own_req = 0;
    external_interrupt_out = 0;
    mem_hit = 1;
    data_par_err = 0;
    assert_perr = 1;
    wt(8);
    check(link.req_wire[1:0], 2'b11);
    check({f_devsel, d_perr}, 2'b11);
    mem_hit = 0;
    assert_devsel = 1;
    wt(8);
    check(link.devsel_wire, 1'b0);
  endtask
  initial
  begin
    t_int();
    t_ext();
    complete_run();
  end
  initial
  begin
    #20000;
    mismatches++;
    complete_run();
  end
endmodule // tb
